// ===== core/mns_frame_sec.sv
`timescale 1ns/100ps
`include "mns_defs.svh"
module mns_frame_sec (
    input  wire logic              clk,         // Node clock
    input  wire logic              reset_n,     // Synchronous reset
    input  wire logic [127:0]      net_key,     // Network key
    input  wire logic [63:0]       own_addr,    // Own long address
    input  wire logic              sec_enable,  // Network security on
    input  wire logic              key_update,  // Key replaced pulse
    input  wire logic              snd_valid,   // Local byte valid
    input  wire logic [7:0]        snd_byte,    // Local covered byte
    input  wire logic              snd_last,    // Local last byte
    input  wire mns_pkg::mns_kind_t snd_kind,   // Local frame kind
    input  wire logic              rcv_valid,   // Radio byte valid
    input  wire logic [7:0]        rcv_byte,    // Radio frame byte
    input  wire logic              rcv_last,    // Radio last byte
    input  wire logic [2:0]        rcv_nbr,     // Sending neighbour
    input  wire logic              rcv_for_me,  // Frame ends here
    output logic [7:0]             out_byte,    // Radio out byte
    output logic                   out_valid,   // Radio out valid
    output logic                   out_last,    // Radio out last
    output logic                   busy,        // Frame in progress
    output logic                   rcv_ok,      // Frame accepted
    output logic                   rcv_replay,  // Replay dropped
    output logic                   rcv_bad_mic, // Code mismatch dropped
    output logic                   snd_refused, // Send refused
    output logic [31:0]            frame_count, // Own frame counter
    output logic [7:0]             key_seq      // Key sequence number
);
    import mns_pkg::*;

    mns_core_t   s;
    mns_core_t   next_s;
    mns_mic_if   mic_bus ();
    logic        m_clr;
    logic        m_en;
    logic [7:0]  m_data;
    logic        take;
    logic        fin;
    logic [7:0]  b;
    logic [7:0]  plain;
    logic [7:0]  boff;
    logic [7:0]  hl;
    logic [7:0]  ml;
    logic [6:0]  mi;
    logic [111:0] hdr;
    logic [31:0] rx_fc;
    logic [31:0] rx_mic;
    logic        replay;
    logic        micbad;

    function automatic logic [7:0] ks(input logic [127:0] key,
                                      input logic [31:0]  fc,
                                      input logic [7:0]   off);
        ks = key[{off[3:0], 3'b000} +: 8] ^ fc[{off[1:0], 3'b000} +: 8]
             ^ off;
    endfunction : ks

    assign mic_bus.clr  = m_clr;
    assign mic_bus.en   = m_en;
    assign mic_bus.data = m_data;
    assign mic_bus.key  = net_key;

    mns_mic u_mic (
        .clk     (clk),
        .reset_n (reset_n),
        .bus     (mic_bus.eng)
    );

    assign rx_fc  = {s.mem[3], s.mem[2], s.mem[1], s.mem[0]};
    assign mi     = s.len[6:0] - 7'h04;
    assign rx_mic = {s.mem[mi + 7'h03], s.mem[mi + 7'h02],
                     s.mem[mi + 7'h01], s.mem[mi]};
    assign replay = rx_fc < s.nbr[s.nbr_id];
    assign micbad = mic_bus.mic != rx_mic;
    assign hdr    = {s.key_seq, `MNS_SEC_CTRL, own_addr, s.txfc};
    assign hl     = s.secure ? `MNS_HDR_LEN : 8'h00;
    assign ml     = s.secure ? `MNS_MIC_LEN : 8'h00;

    always_comb begin
        next_s             = s;
        m_clr              = 1'b0;
        m_en               = 1'b0;
        m_data             = 8'h00;
        take               = 1'b0;
        fin                = 1'b0;
        b                  = 8'h00;
        plain              = 8'h00;
        boff               = 8'h00;
        next_s.out_valid   = 1'b0;
        next_s.out_last    = 1'b0;
        next_s.rcv_ok      = 1'b0;
        next_s.rcv_replay  = 1'b0;
        next_s.rcv_bad_mic = 1'b0;
        next_s.snd_refused = 1'b0;
        case (s.state)
            ST_IDLE, ST_LOAD: begin
                if (s.state == ST_IDLE) begin
                    if (rcv_valid) begin
                        next_s.rx_mode = 1'b1;
                        next_s.nbr_id  = rcv_nbr;
                        next_s.for_me  = rcv_for_me;
                        take = 1'b1;
                        fin  = rcv_last;
                        b    = rcv_byte;
                    end else if (snd_valid) begin
                        next_s.rx_mode = 1'b0;
                        next_s.kind    = snd_kind;
                        take = 1'b1;
                        fin  = snd_last;
                        b    = snd_byte;
                    end
                end else if (s.rx_mode && rcv_valid) begin
                    take = 1'b1;
                    fin  = rcv_last;
                    b    = rcv_byte;
                end else if (!s.rx_mode && snd_valid) begin
                    take = 1'b1;
                    fin  = snd_last;
                    b    = snd_byte;
                end
                if (take) begin
                    next_s.state = ST_LOAD;
                    if (s.idx < `MNS_MAX_FRAME) begin
                        next_s.mem[s.idx[6:0]] = b;
                        next_s.idx = s.idx + 8'h01;
                    end else begin
                        next_s.ovf = 1'b1;
                    end
                end
                if (take && fin && next_s.rx_mode) begin
                    next_s.len = next_s.idx;
                    if (next_s.ovf || next_s.idx < `MNS_OVERHEAD) begin
                        next_s.rcv_bad_mic = 1'b1;
                        next_s.state = ST_IDLE;
                    end else begin
                        m_clr        = 1'b1;
                        next_s.pos   = 8'h00;
                        next_s.state = ST_AUTH;
                    end
                end else if (take && fin) begin
                    next_s.secure = sec_enable
                        && next_s.kind != MNS_KIND_BEACON;
                    if (next_s.ovf || (next_s.secure
                        && (next_s.idx > `MNS_MAX_COVER
                        || s.fc == `MNS_FC_MAX))) begin
                        next_s.snd_refused = 1'b1;
                        next_s.state = ST_IDLE;
                    end else begin
                        m_clr        = 1'b1;
                        next_s.base  = 8'h00;
                        next_s.blen  = next_s.idx;
                        next_s.pos   = 8'h00;
                        next_s.state = ST_SEND;
                        if (next_s.secure) begin
                            next_s.txfc = s.fc;
                            next_s.fc   = s.fc + `MNS_FC_ONE;
                        end
                    end
                end
            end
            ST_AUTH: begin
                b = s.mem[s.pos[6:0]];
                if (s.pos >= `MNS_HDR_LEN) begin
                    plain = b ^ ks(net_key, rx_fc, s.pos - `MNS_HDR_LEN);
                    next_s.mem[s.pos[6:0]] = plain;
                end else begin
                    plain = b;
                end
                m_en   = 1'b1;
                m_data = plain;
                if (s.pos == s.len - `MNS_MIC_LEN - 8'h01) begin
                    next_s.state = ST_VERDICT;
                end else begin
                    next_s.pos = s.pos + 8'h01;
                end
            end
            ST_VERDICT: begin
                next_s.state = ST_IDLE;
                if (replay) begin
                    next_s.rcv_replay = 1'b1;
                end else if (micbad) begin
                    next_s.rcv_bad_mic = 1'b1;
                end else begin
                    next_s.nbr[s.nbr_id] = rx_fc;
                    next_s.rcv_ok = 1'b1;
                    if (!s.for_me && s.fc == `MNS_FC_MAX) begin
                        next_s.snd_refused = 1'b1;
                    end else if (!s.for_me) begin
                        m_clr         = 1'b1;
                        next_s.secure = 1'b1;
                        next_s.base   = `MNS_HDR_LEN;
                        next_s.blen   = s.len - `MNS_OVERHEAD;
                        next_s.pos    = 8'h00;
                        next_s.txfc   = s.fc;
                        next_s.fc     = s.fc + `MNS_FC_ONE;
                        next_s.state  = ST_SEND;
                    end
                end
            end
            ST_SEND: begin
                next_s.out_valid = 1'b1;
                if (s.pos < hl) begin
                    b = hdr[{s.pos[3:0], 3'b000} +: 8];
                    next_s.out_byte = b;
                    m_en   = 1'b1;
                    m_data = b;
                end else if (s.pos < hl + s.blen) begin
                    boff  = s.pos - hl;
                    plain = s.mem[s.base[6:0] + boff[6:0]];
                    next_s.out_byte = s.secure
                        ? plain ^ ks(net_key, s.txfc, boff)
                        : plain;
                    m_en   = s.secure;
                    m_data = plain;
                end else begin
                    boff = s.pos - hl - s.blen;
                    next_s.out_byte =
                        mic_bus.mic[{boff[1:0], 3'b000} +: 8];
                end
                if (s.pos == hl + s.blen + ml - 8'h01) begin
                    next_s.out_last = 1'b1;
                    next_s.state = ST_IDLE;
                end else begin
                    next_s.pos = s.pos + 8'h01;
                end
            end
            default: begin
                next_s.state = ST_IDLE;
            end
        endcase
        if (key_update) begin
            next_s.fc      = 32'h00000000;
            next_s.nbr     = '0;
            next_s.key_seq = s.key_seq + 8'h01;
        end
        if (next_s.state == ST_IDLE) begin
            next_s.idx = 8'h00;
            next_s.ovf = 1'b0;
        end
        next_s.busy = next_s.state != ST_IDLE;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign out_byte    = s.out_byte;
    assign out_valid   = s.out_valid;
    assign out_last    = s.out_last;
    assign busy        = s.busy;
    assign rcv_ok      = s.rcv_ok;
    assign rcv_replay  = s.rcv_replay;
    assign rcv_bad_mic = s.rcv_bad_mic;
    assign snd_refused = s.snd_refused;
    assign frame_count = s.fc;
    assign key_seq     = s.key_seq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence hdr_fc_seq;
        s.out_byte == s.txfc[7:0] ##1 s.out_byte == s.txfc[15:8]
        ##1 s.out_byte == s.txfc[23:16] ##1 s.out_byte == s.txfc[31:24];
    endsequence

    sequence mic_tail_seq;
        s.out_byte == mic_bus.mic[7:0] ##1 s.out_byte == mic_bus.mic[15:8]
        ##1 s.out_byte == mic_bus.mic[23:16]
        ##1 (s.out_byte == mic_bus.mic[31:24] && s.out_last);
    endsequence

    chk_header_counter: assert property (
        (s.state == ST_SEND && s.secure && s.pos == 8'h00) |=> hdr_fc_seq)
        else $error("frame counter missing from header");
    chk_counter_step: assert property (
        ($changed(s.fc) && !$past(key_update))
        |-> s.fc == $past(s.fc) + `MNS_FC_ONE)
        else $error("own counter moved by other than one");
    chk_counter_sticky: assert property (
        (s.fc == `MNS_FC_MAX && !key_update) |=> s.fc == `MNS_FC_MAX)
        else $error("own counter left saturation");
    chk_key_clear: assert property (
        key_update |=> (s.fc == 32'h00000000 && s.nbr == '0))
        else $error("counters not cleared on key change");
    chk_key_seq_step: assert property (
        key_update |=> s.key_seq == $past(s.key_seq) + 8'h01)
        else $error("key sequence not advanced");
    chk_replay_drop: assert property (
        (s.state == ST_VERDICT && replay)
        |=> (s.rcv_replay && !s.rcv_ok))
        else $error("replayed frame not dropped");
    chk_mic_drop: assert property (
        (s.state == ST_VERDICT && !replay && micbad)
        |=> (s.rcv_bad_mic && !s.rcv_ok))
        else $error("bad integrity code not dropped");
    chk_nbr_store: assert property (
        (s.rcv_ok && !$past(key_update)) |-> s.nbr[s.nbr_id] == rx_fc)
        else $error("neighbour counter not replaced");
    chk_relay_resecure: assert property (
        (s.state == ST_VERDICT && !replay && !micbad && !s.for_me
         && s.fc != `MNS_FC_MAX && !key_update)
        |=> (s.state == ST_SEND && s.secure && s.txfc == $past(s.fc)))
        else $error("relay not re-secured with own counter");
    chk_mic_tail: assert property (
        (s.state == ST_SEND && s.secure && s.pos == hl + s.blen)
        |=> mic_tail_seq)
        else $error("integrity code not at frame end");
    chk_beacon_plain: assert property (
        (s.state == ST_SEND && !s.secure && !key_update) |=> $stable(s.fc))
        else $error("unsecured frame advanced counter");
    chk_payload_limit: assert property (
        (s.state == ST_SEND && s.secure)
        |-> s.blen + `MNS_OVERHEAD <= `MNS_MAX_FRAME)
        else $error("secured frame exceeds size limit");
endmodule : mns_frame_sec

// ===== core/mns_defs.svh
// Function
// - Secured frames carry a 32-bit frame counter in the network header.
// - One own outgoing frame counter, advanced by one per secured send.
// - Keep the last accepted 32-bit counter for each neighbour.
// - Drop a received frame whose counter is below the stored one.
// - Own counter saturates at all ones; secured sends and relays are refused once saturated.
// - A network key change clears own and all neighbour counters to zero.
// - Integrity code covers both headers and payload, keyed with AES-128; the code uses a keyed mixing stand-in for AES.
// - The 4-byte integrity code is appended at the very end of the frame.
// - Recompute the integrity code on receipt; drop the frame on mismatch.
// - Every hop decrypts and authenticates each secured frame.
// - Relays are re-secured with own counter and own source address.
// - Security adds 18 bytes; the allowed payload shrinks by that much.
// - Route, support and device-object commands are secured like data.
// - Medium-access frames such as beacons skip network security.
// - Security on: every data frame is encrypted with the network key.
// - A network key change also advances the key sequence number.
`ifndef MNS_DEFS_SVH
`define MNS_DEFS_SVH
`define MNS_FC_MAX     32'hFFFFFFFF
`define MNS_FC_ONE     32'h00000001
`define MNS_HDR_LEN    8'h0E
`define MNS_MIC_LEN    8'h04
`define MNS_OVERHEAD   8'h12
`define MNS_MAX_FRAME  8'h7F
`define MNS_MAX_COVER  8'h6D
`define MNS_BUF_DEPTH  128
`define MNS_NBR_NUM    8
`define MNS_SEC_CTRL   8'h28
`define MNS_MIC_INIT   32'h5A5A5A5A
`endif

// ===== core/mns_pkg.sv
`include "mns_defs.svh"
package mns_pkg;
    typedef enum logic [2:0] {
        MNS_KIND_DATA,
        MNS_KIND_ROUTE_REQ,
        MNS_KIND_ROUTE_REPLY,
        MNS_KIND_APS_CMD,
        MNS_KIND_DEV_OBJ_CMD,
        MNS_KIND_BEACON
    } mns_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOAD,
        ST_AUTH,
        ST_VERDICT,
        ST_SEND
    } mns_state_t;

    typedef struct packed {
        mns_state_t                       state;
        logic [`MNS_BUF_DEPTH-1:0][7:0]   mem;
        logic [`MNS_NBR_NUM-1:0][31:0]    nbr;
        logic [31:0]                      fc;
        logic [31:0]                      txfc;
        logic [7:0]                       key_seq;
        logic [7:0]                       idx;
        logic [7:0]                       len;
        logic [7:0]                       base;
        logic [7:0]                       blen;
        logic [7:0]                       pos;
        logic                             rx_mode;
        logic                             secure;
        logic                             ovf;
        logic                             for_me;
        logic [2:0]                       nbr_id;
        mns_kind_t                        kind;
        logic [7:0]                       out_byte;
        logic                             out_valid;
        logic                             out_last;
        logic                             busy;
        logic                             rcv_ok;
        logic                             rcv_replay;
        logic                             rcv_bad_mic;
        logic                             snd_refused;
    } mns_core_t;

    typedef struct packed {
        logic [31:0] mic;
    } mns_mic_st_t;
endpackage : mns_pkg

// ===== core/mns_mic_if.sv
`timescale 1ns/100ps
interface mns_mic_if;
    logic         clr;
    logic         en;
    logic [7:0]   data;
    logic [127:0] key;
    logic [31:0]  mic;
    modport eng  (input clr, input en, input data, input key, output mic);
    modport user (output clr, output en, output data, output key, input mic);
endinterface : mns_mic_if

// ===== core/mns_mic.sv
`timescale 1ns/100ps
`include "mns_defs.svh"
module mns_mic (
    input  wire logic clk,     // Node clock
    input  wire logic reset_n, // Synchronous reset
    mns_mic_if.eng    bus      // Byte feed and running code
);
    import mns_pkg::*;

    mns_mic_st_t r;
    mns_mic_st_t next_r;
    logic [31:0] mix;

    // Keyed mixing stands in for the AES block cipher
    always_comb begin
        next_r = r;
        mix    = r.mic ^ {24'h000000, bus.data} ^ bus.key[63:32]
                 ^ bus.key[95:64];
        if (bus.clr) begin
            next_r.mic = `MNS_MIC_INIT;
        end else if (bus.en) begin
            next_r.mic = {mix[26:0], mix[31:27]}
                         + (bus.key[31:0] ^ bus.key[127:96]);
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign bus.mic = r.mic;
endmodule : mns_mic

// ===== tb/mns_peer.sv
`timescale 1ns/100ps
module mns_peer (
    input  wire logic       clk,       // Node clock
    input  wire logic [7:0] out_byte,  // Node radio out byte
    input  wire logic       out_valid, // Node radio out valid
    input  wire logic       out_last,  // Node radio out last
    output logic            rcv_valid, // Byte valid to node
    output logic [7:0]      rcv_byte,  // Byte to node
    output logic            rcv_last   // Last byte to node
);
    logic [7:0] cap [0:127];
    logic [7:0] prev [0:127];
    int         wp;
    int         cap_len;
    int         prev_len;
    int         frames;

    initial begin
        rcv_valid = 1'b0;
        rcv_byte  = 8'hA5;
        rcv_last  = 1'b0;
        wp        = 0;
        cap_len   = 0;
        prev_len  = 0;
        frames    = 0;
    end

    // Keeps the latest heard frame and the one before it
    always @(posedge clk) begin
        if (out_valid === 1'b1) begin
            if (wp == 0) begin
                prev     = cap;
                prev_len = cap_len;
            end
            cap[wp] = out_byte;
            wp      = wp + 1;
            if (out_last === 1'b1) begin
                cap_len = wp;
                frames  = frames + 1;
                wp      = 0;
            end
        end
    end

    // Replays a heard frame, optionally truncated or with one bit flipped
    task automatic send(input bit old, input int len, input int flip);
        int k;
        for (k = 0; k < len; k++) begin
            @(posedge clk);
            rcv_valid <= 1'b1;
            rcv_byte  <= (old ? prev[k] : cap[k]) ^ {7'h00, k == flip};
            rcv_last  <= (k == len - 1);
        end
        @(posedge clk);
        rcv_valid <= 1'b0;
        rcv_last  <= 1'b0;
        rcv_byte  <= ~rcv_byte;
    endtask : send
endmodule : mns_peer

// ===== tb/mns_frame_sec_bench.sv
`timescale 1ns/100ps
`include "mns_defs.svh"
module mns_frame_sec_bench;
    import mns_pkg::*;
    logic         clk = 1'b0;
    logic         reset_n, sec_enable, key_update;
    logic [127:0] net_key;
    logic [63:0]  own_addr;
    logic         snd_valid, snd_last, rcv_valid, rcv_last, rcv_for_me;
    logic [7:0]   snd_byte, rcv_byte, out_byte, key_seq;
    mns_kind_t    snd_kind;
    logic [2:0]   rcv_nbr;
    logic         out_valid, out_last, busy;
    logic         rcv_ok, rcv_replay, rcv_bad_mic, snd_refused;
    logic [31:0]  frame_count;
    int           seed = 32'h478A;
    int           fail_count = 0;
    int           check_count = 0;
    int           pulses [4] = '{0, 0, 0, 0};
    logic [7:0]   sent [0:127];
    logic [7:0]   seq_exp = 8'h00;

    always #5 clk = ~clk;

    mns_frame_sec i_mns_frame_sec (.clk(clk), .reset_n(reset_n),
        .net_key(net_key), .own_addr(own_addr), .sec_enable(sec_enable),
        .key_update(key_update), .snd_valid(snd_valid),
        .snd_byte(snd_byte), .snd_last(snd_last), .snd_kind(snd_kind),
        .rcv_valid(rcv_valid), .rcv_byte(rcv_byte), .rcv_last(rcv_last),
        .rcv_nbr(rcv_nbr), .rcv_for_me(rcv_for_me), .out_byte(out_byte),
        .out_valid(out_valid), .out_last(out_last), .busy(busy),
        .rcv_ok(rcv_ok), .rcv_replay(rcv_replay),
        .rcv_bad_mic(rcv_bad_mic), .snd_refused(snd_refused),
        .frame_count(frame_count), .key_seq(key_seq));

    mns_peer i_mns_peer (.clk(clk), .out_byte(out_byte),
        .out_valid(out_valid), .out_last(out_last), .rcv_valid(rcv_valid),
        .rcv_byte(rcv_byte), .rcv_last(rcv_last));

    // Verdict pulses: ok, replay, bad code, refused
    always @(posedge clk) begin
        if (reset_n === 1'b1) begin
            pulses[0] += (rcv_ok === 1'b1);
            pulses[1] += (rcv_replay === 1'b1);
            pulses[2] += (rcv_bad_mic === 1'b1);
            pulses[3] += (snd_refused === 1'b1);
        end
    end

    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    // Expected ciphertext of body byte i under counter fc
    function automatic logic [7:0] body_exp(input int i,
                                            input logic [31:0] fc);
        body_exp = sent[i] ^ net_key[8*(i%16) +: 8] ^ fc[8*(i%4) +: 8]
                   ^ 8'(i);
    endfunction : body_exp

    task automatic wait_idle();
        int n;
        int q;
        q = 0;
        for (n = 0; n < 800 && q < 4; n++) begin
            @(posedge clk);
            #1;
            q = (busy === 1'b0) ? q + 1 : 0;
        end
        if (q < 4) check("idle wait", 0, 1);
    endtask : wait_idle

    task automatic local_send(input mns_kind_t k, input int len);
        int i;
        for (i = 0; i < len; i++) begin
            @(posedge clk);
            snd_valid <= 1'b1;
            sent[i]   = 8'($random(seed));
            snd_byte  <= sent[i];
            snd_last  <= (i == len - 1);
            snd_kind  <= k;
        end
        @(posedge clk);
        snd_valid <= 1'b0;
        snd_last  <= 1'b0;
        wait_idle();
    endtask : local_send

    task automatic check_sec(input int len, input logic [31:0] fc);
        int i;
        check("frame length", i_mns_peer.cap_len, len + 18);
        for (i = 0; i < 4; i++)
            check("counter byte", i_mns_peer.cap[i], fc[8*i +: 8]);
        for (i = 0; i < 8; i++)
            check("source byte", i_mns_peer.cap[4+i],
                  own_addr[8*i +: 8]);
        check("control byte", i_mns_peer.cap[12], `MNS_SEC_CTRL);
        check("sequence byte", i_mns_peer.cap[13], seq_exp);
        for (i = 0; i < len; i++)
            check("body", i_mns_peer.cap[14+i], body_exp(i, fc));
    endtask : check_sec

    task automatic rx(input bit old, input logic [2:0] nbr, input logic me,
                      input int len, input int flip, input int which);
        int b [4];
        int j;
        b = pulses;
        @(posedge clk);
        rcv_nbr    <= nbr;
        rcv_for_me <= me;
        i_mns_peer.send(old, len, flip);
        wait_idle();
        for (j = 0; j < 4; j++)
            check("verdict pulses", pulses[j] - b[j], j == which);
    endtask : rx

    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        int          k;
        int          len;
        int          nf;
        int          b3;
        logic [31:0] fc;
        reset_n = 1'b0;
        net_key = {$random(seed), $random(seed),
                   $random(seed), $random(seed)};
        own_addr = {$random(seed), $random(seed)};
        sec_enable = 1'b1;
        key_update = 1'b0;
        snd_valid = 1'b0;
        snd_byte = 8'h00;
        snd_last = 1'b0;
        snd_kind = MNS_KIND_DATA;
        rcv_nbr = 3'h0;
        rcv_for_me = 1'b1;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        check("count after reset", frame_count, 32'h0);
        check("sequence after reset", key_seq, 8'h00);
        fc = 32'h0;
        nf = 0;
        for (k = 0; k < 6; k++) begin
            len = {$random(seed)} % 16 + 1;
            local_send(mns_kind_t'(k[2:0]), len);
            nf++;
            check("frames seen", i_mns_peer.frames, nf);
            if (k == 5) begin
                check("beacon length", i_mns_peer.cap_len, len);
            end else begin
                check_sec(len, fc);
                fc++;
            end
            check("frame count", frame_count, fc);
        end
        sec_enable <= 1'b0;
        local_send(MNS_KIND_DATA, 5);
        nf++;
        check("plain length", i_mns_peer.cap_len, 5);
        check("frame count", frame_count, fc);
        sec_enable <= 1'b1;
        $display("test kinds done");
        local_send(MNS_KIND_DATA, 6);
        local_send(MNS_KIND_DATA, 6);
        nf += 2;
        fc += 2;
        rx(0, 3'h3, 1'b1, 24, -1, 0);
        rx(1, 3'h3, 1'b1, 24, -1, 1);
        rx(0, 3'h3, 1'b1, 24, -1, 0);
        rx(1, 3'h5, 1'b1, 24, -1, 0);
        rx(0, 3'h3, 1'b1, 24, 14, 2);
        rx(0, 3'h3, 1'b1, 17, -1, 2);
        $display("test receive done");
        rx(0, 3'h2, 1'b0, 24, -1, 0);
        nf++;
        check("frames seen", i_mns_peer.frames, nf);
        check_sec(6, fc);
        fc++;
        check("frame count", frame_count, fc);
        $display("test relay done");
        b3 = pulses[3];
        local_send(MNS_KIND_DATA, 110);
        check("refusal pulse", pulses[3] - b3, 1);
        check("frames seen", i_mns_peer.frames, nf);
        local_send(MNS_KIND_DATA, 109);
        nf++;
        check_sec(109, fc);
        fc++;
        $display("test length done");
        @(posedge clk);
        key_update <= 1'b1;
        @(posedge clk);
        key_update <= 1'b0;
        seq_exp = 8'h01;
        @(posedge clk);
        #1;
        check("count cleared", frame_count, 32'h0);
        check("key sequence", key_seq, 8'h01);
        local_send(MNS_KIND_DATA, 3);
        check_sec(3, 32'h0);
        rx(0, 3'h3, 1'b1, 21, -1, 0);
        $display("test key update done");
        tally_and_finish();
    end
endmodule : mns_frame_sec_bench
